// file: gpt_pkg.sv
package gpt_pkg;
  // timer slots
  localparam int unsigned NUM_TIMERS = 5;
  localparam int unsigned AUX_A = 0;
  localparam int unsigned CORE1 = 1;
  localparam int unsigned AUX_B = 2;
  localparam int unsigned COMP = 3;
  localparam int unsigned CORE2 = 4;
  // synchronised pins: inputs, then direction pins, then capture pin
  localparam int unsigned PIN_W = 2 * NUM_TIMERS + 1;
  localparam int unsigned CAP_PIN = 2 * NUM_TIMERS;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CTRL_W = 19;
  localparam int unsigned PRESC_W = 10;
  localparam int unsigned STAT_W = NUM_TIMERS + 1;
  localparam int unsigned CAP_FLAG = NUM_TIMERS;
  // prescaler shift at select code 000b: divide by 8 or by 4
  localparam logic [3:0] FIRST_SHIFT = 4'h3;
  localparam logic [3:0] SECOND_SHIFT = 4'h2;
  // byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] VAL_OFS = 8'h20;
  localparam logic [7:0] CAPTURE_RELOAD_REGISTER_OFS = 8'h40;
  localparam logic [7:0] STATUS_OFS = 8'h44;
  // control word fields
  localparam int unsigned F_ISEL = 0;
  localparam int unsigned F_MODE = 3;
  localparam int unsigned F_RUN = 5;
  localparam int unsigned F_DOWN = 6;
  localparam int unsigned F_EXTDIR = 7;
  localparam int unsigned F_EDGE = 8;
  localparam int unsigned F_GLVL = 10;
  localparam int unsigned F_CHAIN = 11;
  localparam int unsigned F_FUNC = 12;
  localparam int unsigned F_OUTEN = 14;
  localparam int unsigned F_CAPSRC = 15;
  localparam int unsigned F_CAPEDGE = 17;
  // auxiliary timer function codes
  localparam logic [1:0] AUXFN_NONE = 2'h0;
  localparam logic [1:0] AUXFN_RELOAD = 2'h1;
  localparam logic [1:0] AUXFN_CAPTURE = 2'h2;
  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RESET = 19'h00000;
  localparam logic [15:0] TIMER_RESET = 16'h0000;
  localparam logic [STAT_W-1:0] STATUS_RESET = 6'h00;

  typedef enum logic [1:0] {MODE_TIMER, MODE_GATED, MODE_COUNTER, MODE_INCR} mode_t;
endpackage

// file: general_purpose_timer_unit.sv
// Notes on behaviour
// - five 16-bit timers, three in the first module and two in the second
// - a timer may be chained to another timer of its own module
// - first-module timers select timer, gated, counter or incremental mode
// - timer mode counts prescaled CPU clock ticks
// - first module select codes 000b..111b divide by 8 up to 1024
// - counter mode counts selected transitions of the timer input pin
// - gated mode counts prescaled ticks only while the gate pin is active
// - each timer has one input pin serving as gate or count clock
// - incremental mode derives count and direction from encoder A and B
// - first core timer inverts its toggle latch on each overflow or underflow
// - first core latch drives an output pin and clocks both auxiliary timers
// - auxiliary timers may act as reload or capture register of the core
// - second module holds two timers and one capture/reload register
// - second module codes divide by 4 up to 512, or external clocking
// - direction set by software, optionally overridden by the direction pin
// - second core toggles its latch on wrap, clocking companion and output pin
// - second core wrap clocks the compare timers and may reload from capture
// - capture pin edge copies companion timer, optionally clearing it afterwards
// - capture may instead trigger on first core input or direction pin edges
module general_purpose_timer_unit
  import gpt_pkg::*;
#(
  parameter int unsigned TIMER_W = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timer pins
  input wire logic [NUM_TIMERS-1:0] timer_input_pin,
  input wire logic [NUM_TIMERS-1:0] timer_direction_pin,
  input wire logic capture_input_pin,
  output logic toggle_output_pin,
  output logic second_core_toggle_pin,
  output logic ccu_clock_pulse
);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [CTRL_W-1:0] ctrl [NUM_TIMERS];
  logic [TIMER_W-1:0] tval [NUM_TIMERS];
  logic [TIMER_W-1:0] load_val [NUM_TIMERS];
  logic [TIMER_W-1:0] capture_reload_register;
  logic [STAT_W-1:0] status;
  logic [PRESC_W-1:0] presc;
  logic [PIN_W-1:0] sync1, sync2, sync3, rise, fall;
  logic [NUM_TIMERS-1:0] cnt_evt, down, wrap, load_en, wr_val;
  logic output_toggle_latch, second_core_toggle_latch;
  logic wr_en, cap_evt, rel_a, rel_b;
  logic [1:0] cap_sel;

  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    return (sel[0] & r) | (sel[1] & f);
  endfunction

  // tick once every 2**shift cycles of the free-running prescaler
  function automatic logic presc_tick(input logic [PRESC_W-1:0] cnt, input logic [3:0] shift);
    logic [PRESC_W:0] mask;
    mask = (PRESC_W + 1)'((1 << shift) - 1);
    return (cnt & mask[PRESC_W-1:0]) == mask[PRESC_W-1:0];
  endfunction

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = (a == CAPTURE_RELOAD_REGISTER_OFS) || (a == STATUS_OFS);
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (a == CTRL_OFS + ADDR_W'(4 * i) || a == VAL_OFS + ADDR_W'(4 * i)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a);
    logic [31:0] d;
    d = 32'h00000000;
    if (a == CAPTURE_RELOAD_REGISTER_OFS) begin
      d = 32'(capture_reload_register);
    end
    if (a == STATUS_OFS) begin
      d = 32'(status);
    end
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (a == CTRL_OFS + ADDR_W'(4 * i)) begin
        d = 32'(ctrl[i]);
      end
      if (a == VAL_OFS + ADDR_W'(4 * i)) begin
        d = 32'(tval[i]);
      end
    end
    return d;
  endfunction

  // apb: zero wait states, read data sampled in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_hit(paddr);
  assign wr_en = psel & penable & pwrite & addr_hit(paddr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= read_word(paddr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        ctrl[i] <= CTRL_RESET;
      end
    end else if (wr_en) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (paddr == CTRL_OFS + ADDR_W'(4 * i)) begin
          ctrl[i] <= pwdata[CTRL_W-1:0];
        end
      end
    end
  end

  // two-stage synchroniser plus an edge-detect stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= {capture_input_pin, timer_direction_pin, timer_input_pin};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  assign rise = sync2 & ~sync3;
  assign fall = ~sync2 & sync3;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc <= '0;
    end else begin
      presc <= presc + 1'b1;
    end
  end

  assign rel_a = ctrl[AUX_A][F_FUNC +: 2] == AUXFN_RELOAD;
  assign rel_b = ctrl[AUX_B][F_FUNC +: 2] == AUXFN_RELOAD;

  // capture source: capture pin, or the first core timer's input and/or direction pin
  assign cap_sel = ctrl[COMP][F_CAPSRC +: 2];
  always_comb begin
    if (cap_sel == 2'h0) begin
      cap_evt = edge_hit(ctrl[COMP][F_CAPEDGE +: 2], rise[CAP_PIN], fall[CAP_PIN]);
    end else begin
      cap_evt = edge_hit(ctrl[COMP][F_CAPEDGE +: 2],
        (cap_sel[0] & rise[CORE1]) | (cap_sel[1] & rise[NUM_TIMERS + CORE1]),
        (cap_sel[0] & fall[CORE1]) | (cap_sel[1] & fall[NUM_TIMERS + CORE1]));
    end
  end

  // per-timer count logic; slots 0..2 first module, 3..4 second module
  for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_tmr
    localparam logic [3:0] SHIFT = (i <= AUX_B) ? FIRST_SHIFT : SECOND_SHIFT;
    mode_t mode;
    logic tick, a_edge, b_edge, quad_down, ch_r, ch_f, evt, held;

    assign mode = mode_t'(ctrl[i][F_MODE +: 2]);
    assign tick = presc_tick(presc, {1'b0, ctrl[i][F_ISEL +: 3]} + SHIFT);
    assign a_edge = rise[i] | fall[i];
    assign b_edge = rise[NUM_TIMERS + i] | fall[NUM_TIMERS + i];
    // a leading b counts up
    assign quad_down = a_edge ? (sync2[i] == sync2[NUM_TIMERS + i])
                              : (sync2[i] != sync2[NUM_TIMERS + i]);

    if (i == AUX_A || i == AUX_B) begin : g_aux
      assign ch_r = wrap[CORE1] & ~output_toggle_latch;
      assign ch_f = wrap[CORE1] & output_toggle_latch;
      assign held = ctrl[i][F_FUNC +: 2] != AUXFN_NONE;
      assign load_en[i] = (ctrl[i][F_FUNC +: 2] == AUXFN_CAPTURE)
                          & edge_hit(ctrl[i][F_EDGE +: 2], rise[i], fall[i]);
      assign load_val[i] = tval[CORE1];
    end else if (i == CORE1) begin : g_core1
      assign ch_r = 1'b0;
      assign ch_f = 1'b0;
      assign held = 1'b0;
      assign load_en[i] = wrap[CORE1] & (rel_a | rel_b);
      assign load_val[i] = rel_b ? tval[AUX_B] : tval[AUX_A];
    end else if (i == COMP) begin : g_comp
      assign ch_r = wrap[CORE2] & ~second_core_toggle_latch;
      assign ch_f = wrap[CORE2] & second_core_toggle_latch;
      assign held = 1'b0;
      assign load_en[i] = cap_evt & ctrl[COMP][F_FUNC];
      assign load_val[i] = '0;
    end else begin : g_core2
      assign ch_r = 1'b0;
      assign ch_f = 1'b0;
      assign held = 1'b0;
      assign load_en[i] = wrap[CORE2] & ctrl[CORE2][F_FUNC];
      assign load_val[i] = capture_reload_register;
    end

    always_comb begin
      unique case (mode)
        MODE_TIMER: evt = tick;
        MODE_GATED: evt = tick & (sync2[i] == ctrl[i][F_GLVL]);
        MODE_COUNTER: evt = ctrl[i][F_CHAIN] ? edge_hit(ctrl[i][F_EDGE +: 2], ch_r, ch_f)
                                             : edge_hit(ctrl[i][F_EDGE +: 2], rise[i], fall[i]);
        MODE_INCR: evt = a_edge ^ b_edge;
      endcase
    end

    assign cnt_evt[i] = ctrl[i][F_RUN] & ~held & evt;
    assign down[i] = (mode == MODE_INCR) ? (quad_down ^ ctrl[i][F_DOWN])
                   : (ctrl[i][F_EXTDIR] ? sync2[NUM_TIMERS + i] : ctrl[i][F_DOWN]);
    assign wrap[i] = cnt_evt[i] & (down[i] ? (tval[i] == '0) : (tval[i] == '1));
    assign wr_val[i] = wr_en & (paddr == VAL_OFS + ADDR_W'(4 * i));

    property p_gate_hold;
      (ctrl[i][F_RUN] && mode == MODE_GATED && sync2[i] != ctrl[i][F_GLVL] && !wr_val[i] && !load_en[i])
        |=> $stable(tval[i]);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("gated timer counted with gate inactive");

    property p_step_up;
      (mode == MODE_TIMER && cnt_evt[i] && !down[i] && !wr_val[i] && !load_en[i])
        |=> tval[i] == TIMER_W'($past(tval[i]) + 1'b1);
    endproperty
    a_step_up: assert property (p_step_up) else $error("timer did not advance by one on tick");

    property p_wrap_flag;
      wrap[i] |=> status[i];
    endproperty
    a_wrap_flag: assert property (p_wrap_flag) else $error("wrap did not set request flag");
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        tval[i] <= TIMER_W'(TIMER_RESET);
      end
    end else begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (wr_val[i]) begin
          tval[i] <= pwdata[TIMER_W-1:0];
        end else if (load_en[i]) begin
          tval[i] <= load_val[i];
        end else if (cnt_evt[i]) begin
          tval[i] <= down[i] ? tval[i] - 1'b1 : tval[i] + 1'b1;
        end
      end
    end
  end

  // hardware capture wins over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_reload_register <= TIMER_W'(TIMER_RESET);
    end else if (cap_evt) begin
      capture_reload_register <= tval[COMP];
    end else if (wr_en && paddr == CAPTURE_RELOAD_REGISTER_OFS) begin
      capture_reload_register <= pwdata[TIMER_W-1:0];
    end
  end

  // request flags: write one to clear, a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= STATUS_RESET;
    end else if (wr_en && paddr == STATUS_OFS) begin
      status <= (status & ~pwdata[STAT_W-1:0]) | {cap_evt, wrap};
    end else begin
      status <= status | {cap_evt, wrap};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_toggle_latch <= 1'b0;
      second_core_toggle_latch <= 1'b0;
      toggle_output_pin <= 1'b0;
      second_core_toggle_pin <= 1'b0;
      ccu_clock_pulse <= 1'b0;
    end else begin
      output_toggle_latch <= output_toggle_latch ^ wrap[CORE1];
      second_core_toggle_latch <= second_core_toggle_latch ^ wrap[CORE2];
      toggle_output_pin <= (output_toggle_latch ^ wrap[CORE1]) & ctrl[CORE1][F_OUTEN];
      second_core_toggle_pin <= (second_core_toggle_latch ^ wrap[CORE2]) & ctrl[CORE2][F_OUTEN];
      ccu_clock_pulse <= wrap[CORE2];
    end
  end

  property p_presc_first;
    (cnt_evt[CORE1] && ctrl[CORE1][F_MODE +: 2] == 2'h0 && ctrl[CORE1][F_ISEL +: 3] == 3'h0)
      |=> (!cnt_evt[CORE1])[*7];
  endproperty
  a_presc_first: assert property (p_presc_first) else $error("first module divide by 8 violated");

  property p_presc_second;
    (cnt_evt[CORE2] && ctrl[CORE2][F_MODE +: 2] == 2'h0 && ctrl[CORE2][F_ISEL +: 3] == 3'h0)
      |=> (!cnt_evt[CORE2])[*3];
  endproperty
  a_presc_second: assert property (p_presc_second) else $error("second module divide by 4 violated");

  property p_latch_first;
    wrap[CORE1] |=> output_toggle_latch != $past(output_toggle_latch);
  endproperty
  a_latch_first: assert property (p_latch_first) else $error("first core latch did not toggle");

  property p_latch_second;
    wrap[CORE2] && ctrl[CORE2][F_OUTEN] |=> second_core_toggle_pin == second_core_toggle_latch;
  endproperty
  a_latch_second: assert property (p_latch_second) else $error("second core pin not following latch");

  property p_ccu;
    wrap[CORE2] |=> ccu_clock_pulse ##1 (!ccu_clock_pulse || $past(wrap[CORE2]));
  endproperty
  a_ccu: assert property (p_ccu) else $error("compare clock pulse missing");

  property p_reload;
    wrap[CORE2] && ctrl[CORE2][F_FUNC] && !wr_val[CORE2] |=> tval[CORE2] == $past(capture_reload_register);
  endproperty
  a_reload: assert property (p_reload) else $error("second core not reloaded");

  property p_aux_reload;
    wrap[CORE1] && rel_a && !rel_b && !wr_val[CORE1] |=> tval[CORE1] == $past(tval[AUX_A]);
  endproperty
  a_aux_reload: assert property (p_aux_reload) else $error("core not reloaded from auxiliary");

  property p_capture;
    cap_evt |=> capture_reload_register == $past(tval[COMP]) && status[CAP_FLAG];
  endproperty
  a_capture: assert property (p_capture) else $error("capture did not copy companion timer");

  property p_clear;
    cap_evt && ctrl[COMP][F_FUNC] && !wr_val[COMP] |=> tval[COMP] == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("companion timer not cleared after capture");

  property p_sync;
    rise[CAP_PIN] |-> $past(capture_input_pin, 2) && !$past(capture_input_pin, 3);
  endproperty
  a_sync: assert property (p_sync) else $error("capture edge not two flops behind pin");

  // chained companion must see every latch change when both edges are selected
  property p_chain_second;
    ctrl[COMP][F_RUN] && ctrl[COMP][F_MODE +: 2] == 2'h2 && ctrl[COMP][F_CHAIN]
      && ctrl[COMP][F_EDGE +: 2] == 2'h3 && wrap[CORE2] |-> cnt_evt[COMP];
  endproperty
  a_chain_second: assert property (p_chain_second) else $error("companion missed latch edge");

  property p_aux_capture;
    load_en[AUX_A] && !wr_val[AUX_A] |=> tval[AUX_A] == $past(tval[CORE1]);
  endproperty
  a_aux_capture: assert property (p_aux_capture) else $error("auxiliary did not capture core");

  property p_unmapped;
    psel && penable && paddr[1:0] != 2'h0 |-> pslverr && !wr_en;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("misaligned access not refused");

  c_chain: cover property (cnt_evt[COMP] && ctrl[COMP][F_CHAIN]);
  c_core1_wrap: cover property (wrap[CORE1]);
  c_capture: cover property (cap_evt && ctrl[COMP][F_FUNC]);
  c_core2_reload: cover property (wrap[CORE2] && ctrl[CORE2][F_FUNC]);
  c_incremental: cover property (cnt_evt[CORE1] && ctrl[CORE1][F_MODE +: 2] == 2'h3);

endmodule

// file: gpt_pin_partner.sv
module gpt_pin_partner
  import gpt_pkg::*;
(
  // clock
  input wire logic pclk,
  // pins toward the timer unit
  output logic [NUM_TIMERS-1:0] timer_input_pin,
  output logic [NUM_TIMERS-1:0] timer_direction_pin,
  output logic capture_input_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  int phase = 0;
  initial begin
    timer_input_pin = '0;
    timer_direction_pin = '0;
    capture_input_pin = 1'b0;
  end
  // levels stand three clocks, above the one-clock minimum of the synchroniser
  task automatic pulse_in(input int idx, input int n);
    for (int i = 0; i < n; i++) begin
      timer_input_pin[idx] <= 1'b1;
      repeat (3) @(posedge pclk);
      timer_input_pin[idx] <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask
  task automatic pulse_cap;
    capture_input_pin <= 1'b1;
    repeat (3) @(posedge pclk);
    capture_input_pin <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic set_pin(input int idx, input logic dir, input logic v);
    if (dir) timer_direction_pin[idx] <= v;
    else timer_input_pin[idx] <= v;
    @(posedge pclk);
  endtask
  // encoder: one of a and b changes per step, a leads b when moving forward
  task automatic quad(input int idx, input int steps, input logic fwd);
    for (int i = 0; i < steps; i++) begin
      phase = (phase + (fwd ? 1 : 3)) % 4;
      timer_input_pin[idx] <= (phase == 1 || phase == 2);
      timer_direction_pin[idx] <= (phase >= 2);
      repeat (3) @(posedge pclk);
    end
  endtask
endmodule

// file: general_purpose_timer_unit_tb.sv
module general_purpose_timer_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import gpt_pkg::*;
  `define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin fails++; \
    $display("[FAIL] %s expected %h seen %h", what, exp, got); end end
  typedef struct {logic wr; logic err; logic [31:0] lo; logic [31:0] hi;} note_t;
  localparam int run_b = 1 << F_RUN;
  localparam int rise_b = 1 << F_EDGE;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, toggle_output_pin, second_core_toggle_pin, ccu_clock_pulse, capture_input_pin;
  logic [NUM_TIMERS-1:0] timer_input_pin, timer_direction_pin;
  note_t notes[$];
  note_t got_note;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  int ccu_count = 0;
  int seed = 69224;
  int n, t, p;
  always #25 pclk = ~pclk;
  general_purpose_timer_unit general_purpose_timer_unit_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_input_pin(timer_input_pin), .timer_direction_pin(timer_direction_pin),
    .capture_input_pin(capture_input_pin), .toggle_output_pin(toggle_output_pin),
    .second_core_toggle_pin(second_core_toggle_pin), .ccu_clock_pulse(ccu_clock_pulse));
  gpt_pin_partner gpt_pin_partner_i (.pclk(pclk), .timer_input_pin(timer_input_pin),
    .timer_direction_pin(timer_direction_pin), .capture_input_pin(capture_input_pin));
  function automatic logic [7:0] va(input int i);
    return VAL_OFS + 8'(4 * i);
  endfunction
  function automatic logic [7:0] ca(input int i);
    return CTRL_OFS + 8'(4 * i);
  endfunction
  function automatic logic [31:0] cw(input mode_t m, input int sel, input int bits);
    return 32'(sel) | (32'(m) << F_MODE) | 32'(bits);
  endfunction
  function automatic logic unmapped(input logic [7:0] a);
    return a[1:0] != 2'h0 || !(a <= CTRL_OFS + 8'h10 || (a >= VAL_OFS && a <= VAL_OFS + 8'h10)
      || a == CAPTURE_RELOAD_REGISTER_OFS || a == STATUS_OFS);
  endfunction
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // one transfer; the expected answer is queued before the request goes out
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] lo,
    input logic [31:0] hi);
    notes.push_back('{w, unmapped(a), lo, hi});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 32'h0, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
    apb(a, 1'b0, 32'h0, lo, hi);
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (ccu_clock_pulse === 1'b1) ccu_count++;
    if (cycles == 60000) begin
      fails++;
      print_verdict();
    end
  end
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      got_note = notes.pop_front();
      `CHK("pslverr", got_note.err, pslverr)
      if (!got_note.wr && got_note.lo == got_note.hi) begin
        `CHK("prdata", got_note.lo, prdata)
      end else if (!got_note.wr) begin
        `CHK("prdata in range", 1'b1, (prdata >= got_note.lo && prdata <= got_note.hi))
      end
    end
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("toggle pin", 1'b0, toggle_output_pin)
    rd(ca(CORE1), 32'h0, 32'h0);
    rd(va(AUX_A), 32'h0, 32'h0);
    rd(CAPTURE_RELOAD_REGISTER_OFS, 32'h0, 32'h0);
    rd(STATUS_OFS, 32'h0, 32'h0);
    rd(8'h48, 32'h0, 32'h0);
    rd(8'h42, 32'h0, 32'h0);
    wr(8'h4C, 32'hFFFFFFFF);
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 8; c++) begin
        t = m ? CORE2 : CORE1;
        p = 1 << (c + (m ? SECOND_SHIFT : FIRST_SHIFT));
        wr(va(t), 32'hFFFE);
        wr(ca(t), cw(MODE_TIMER, c, run_b | (1 << F_OUTEN)));
        repeat (p / 2 - 2) @(posedge pclk);
        rd(STATUS_OFS, 32'h0, 32'h0);
        repeat (2 * p + 4) @(posedge pclk);
        rd(STATUS_OFS, 32'h1 << t, 32'h1 << t);
        `CHK("toggle pin", ~c[0], m ? second_core_toggle_pin : toggle_output_pin)
        if (m == 1) `CHK("ccu pulses", c + 1, ccu_count)
        wr(ca(t), 32'h0);
        wr(STATUS_OFS, 32'h3F);
      end
    end
    // reload of both core timers on their wrap
    wr(CAPTURE_RELOAD_REGISTER_OFS, 32'hFFF0);
    wr(va(CORE2), 32'hFFFF);
    wr(ca(CORE2), cw(MODE_TIMER, 0, run_b | (1 << F_FUNC)));
    wr(ca(AUX_A), 32'(AUXFN_RELOAD) << F_FUNC);
    wr(va(AUX_A), 32'h1234);
    wr(va(CORE1), 32'hFFFF);
    wr(ca(CORE1), cw(MODE_TIMER, 0, run_b));
    repeat (12) @(posedge pclk);
    rd(va(CORE2), 32'hFFF0, 32'hFFFC);
    rd(va(CORE1), 32'h1234, 32'h1238);
    wr(ca(CORE2), 32'h0);
    wr(ca(CORE1), 32'h0);
    // counter mode with a random number of pin pulses
    n = ($unsigned($random(seed)) % 8) + 1;
    wr(va(AUX_A), 32'h0);
    wr(ca(AUX_A), cw(MODE_COUNTER, 0, run_b | rise_b));
    gpt_pin_partner_i.pulse_in(AUX_A, n);
    rd(va(AUX_A), 32'(n), 32'(n));
    wr(ca(AUX_A), cw(MODE_COUNTER, 0, run_b | rise_b | (1 << F_EXTDIR)));
    gpt_pin_partner_i.set_pin(AUX_A, 1'b1, 1'b1);
    gpt_pin_partner_i.pulse_in(AUX_A, 1);
    rd(va(AUX_A), 32'(n - 1), 32'(n - 1));
    gpt_pin_partner_i.set_pin(AUX_A, 1'b1, 1'b0);
    wr(ca(AUX_A), cw(MODE_COUNTER, 0, run_b | (3 << F_EDGE) | (1 << F_DOWN)));
    gpt_pin_partner_i.pulse_in(AUX_A, 1);
    rd(va(AUX_A), 32'((n - 3) & 16'hFFFF), 32'((n - 3) & 16'hFFFF));
    // gated counting measures the gate pulse
    wr(ca(AUX_B), cw(MODE_GATED, 0, run_b | (1 << F_GLVL)));
    repeat (40) @(posedge pclk);
    rd(va(AUX_B), 32'h0, 32'h0);
    gpt_pin_partner_i.set_pin(AUX_B, 1'b0, 1'b1);
    repeat (80) @(posedge pclk);
    gpt_pin_partner_i.set_pin(AUX_B, 1'b0, 1'b0);
    repeat (6) @(posedge pclk);
    rd(va(AUX_B), 32'h8, 32'hC);
    // encoder forward then back to the start
    wr(va(CORE1), 32'h0);
    wr(ca(CORE1), cw(MODE_INCR, 0, run_b));
    gpt_pin_partner_i.quad(CORE1, 8, 1'b1);
    rd(va(CORE1), 32'h1, 32'h8);
    gpt_pin_partner_i.quad(CORE1, 8, 1'b0);
    rd(va(CORE1), 32'h0, 32'h0);
    wr(ca(CORE1), 32'h0);
    // capture of the companion timer, with clearing
    wr(STATUS_OFS, 32'h3F);
    wr(ca(COMP), cw(MODE_COUNTER, 0, run_b | rise_b | (1 << F_FUNC) | (1 << F_CAPEDGE)));
    gpt_pin_partner_i.pulse_in(COMP, 3);
    gpt_pin_partner_i.pulse_cap();
    rd(CAPTURE_RELOAD_REGISTER_OFS, 32'h3, 32'h3);
    rd(va(COMP), 32'h0, 32'h0);
    rd(STATUS_OFS, 32'h1 << CAP_FLAG, 32'h1 << CAP_FLAG);
    wr(ca(COMP), cw(MODE_COUNTER, 0, run_b | rise_b | (1 << F_FUNC) | (1 << F_CAPEDGE) | (1 << F_CAPSRC)));
    gpt_pin_partner_i.pulse_in(COMP, 2);
    gpt_pin_partner_i.pulse_in(CORE1, 1);
    rd(CAPTURE_RELOAD_REGISTER_OFS, 32'h2, 32'h2);
    // auxiliary captures the first core value on its own pin edge
    wr(va(CORE1), 32'h5A5A);
    wr(ca(AUX_A), (32'(AUXFN_CAPTURE) << F_FUNC) | rise_b);
    gpt_pin_partner_i.pulse_in(AUX_A, 1);
    rd(va(AUX_A), 32'h5A5A, 32'h5A5A);
    // companion counts both edges of the second core latch, core reloads every two ticks
    wr(CAPTURE_RELOAD_REGISTER_OFS, 32'hFFFE);
    wr(va(COMP), 32'h0);
    wr(ca(COMP), cw(MODE_COUNTER, 0, run_b | (3 << F_EDGE) | (1 << F_CHAIN)));
    wr(va(CORE2), 32'hFFFF);
    wr(ca(CORE2), cw(MODE_TIMER, 0, run_b | (1 << F_FUNC)));
    repeat (40) @(posedge pclk);
    wr(ca(CORE2), 32'h0);
    rd(va(COMP), 32'h5, 32'h6);
    print_verdict();
  end
endmodule
